// ### pkg/cawd_pkg.sv
// package for the counter array watchdog: register map, fields, reset values
package cawd_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_COUNTER_MODE   = 4'h0;
  localparam logic [3:0] OFF_COUNTER_CTRL   = 4'h1;
  localparam logic [3:0] OFF_COUNTER_LOW    = 4'h2;
  localparam logic [3:0] OFF_COUNTER_HIGH   = 4'h3;
  localparam logic [3:0] OFF_M4_MODE        = 4'h4;
  localparam logic [3:0] OFF_M4_COMPARE_LOW = 4'h5;
  localparam logic [3:0] OFF_M4_COMPARE_HIGH = 4'h6;
  localparam logic [3:0] OFF_WD_STATUS      = 4'h7;
  // field positions
  localparam int unsigned BIT_WD_ENABLE   = 6;
  localparam int unsigned BIT_RUN         = 6;
  localparam int unsigned BIT_OVERFLOW    = 7;
  localparam int unsigned BIT_M4_MATCH    = 4;
  localparam int unsigned BIT_M4_COMPARE  = 6;
  localparam int unsigned BIT_M4_TOGGLE   = 2;
  localparam int unsigned BIT_WD_FIRED    = 0;
  // reset values
  localparam logic [7:0]  RST_COUNTER_MODE = 8'h00;
  localparam logic [7:0]  RST_M4_MODE      = 8'h00;
  localparam logic [15:0] RST_COMPARE      = 16'h0000;
  localparam logic [15:0] RST_COUNTER      = 16'h0000;
  // internal reset pulse length in cycles
  localparam logic [3:0]  WD_PULSE_CYCLES  = 4'h4;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cawd_bus_t;
endpackage : cawd_pkg

// ### logic/cawd_top.sv
// counter array watchdog: shared counter, module 4 compare and watchdog reset
// How it works
// - only module 4 compare can raise the watchdog reset
// - with watchdog off, module 4 still matches and flags normally
// - 16-bit compare value held in low/high pair, compared with counter
// - counter equals compare while enabled produces internal reset
// - reset is internal only; no reset pin is driven
// - clearing enable before match suppresses reset; setting re-arms
// - counter rolling from maximum to zero sets overflow flag
`timescale 1ns/1ps
`default_nettype none
module cawd_top #(
  parameter int unsigned PULSE_W = cawd_pkg::WD_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_SYS_RST,
  // count pulse source from inside the counter array
  input  wire logic       I_COUNT_TICK,
  // register port
  input  wire logic [3:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  // internal reset and match outputs
  output logic            O_WD_RESET,
  output logic            O_M4_MATCH
);
  cawd_pkg::cawd_bus_t bus;
  logic [7:0]  counter_mode;
  logic [7:0]  m4_mode;
  logic [15:0] compare;
  logic [15:0] counter;
  logic        run;
  logic        overflow;
  logic        m4_flag;
  logic        wd_fired;
  logic [3:0]  pulse_cnt;
  logic [7:0]  rdata;
  logic [7:0]  next_counter_mode;
  logic [7:0]  next_m4_mode;
  logic [15:0] next_compare;
  logic [15:0] next_counter;
  logic        next_run;
  logic        next_overflow;
  logic        next_m4_flag;
  logic        next_wd_fired;
  logic [3:0]  next_pulse_cnt;
  logic [7:0]  next_rdata;
  logic        inc;
  logic        match;
  logic        wd_en;
  logic        wd_hit;
  logic        count_wr;
  logic        cmp_wr;

  assign bus   = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign inc   = run & I_COUNT_TICK;
  assign wd_en = counter_mode[cawd_pkg::BIT_WD_ENABLE];
  // match only sampled as the counter steps, so a static equal value fires once
  assign match = inc && (counter + 16'h0001) == compare && m4_mode[cawd_pkg::BIT_M4_COMPARE];
  assign wd_hit = match & wd_en;
  // software moves of the time base override a step; compare moves leave the step alone
  assign count_wr = bus.wr && (bus.addr == cawd_pkg::OFF_COUNTER_LOW ||
                               bus.addr == cawd_pkg::OFF_COUNTER_HIGH);
  assign cmp_wr   = bus.wr && (bus.addr == cawd_pkg::OFF_M4_COMPARE_LOW ||
                               bus.addr == cawd_pkg::OFF_M4_COMPARE_HIGH);

  always_comb begin
    next_counter_mode = counter_mode;
    next_m4_mode      = m4_mode;
    next_compare      = compare;
    next_run          = run;
    next_counter      = inc ? counter + 16'h0001 : counter;
    next_overflow     = overflow;
    next_m4_flag      = m4_flag;
    next_wd_fired     = wd_fired;
    next_pulse_cnt    = (pulse_cnt != 4'h0) ? pulse_cnt - 4'h1 : 4'h0;
    next_rdata        = 8'h00;
    // a counter byte write wins over a step in the same cycle
    if (bus.wr) begin
      if (bus.addr == cawd_pkg::OFF_COUNTER_MODE) begin
        next_counter_mode = bus.wdata;
      end else if (bus.addr == cawd_pkg::OFF_COUNTER_CTRL) begin
        next_run      = bus.wdata[cawd_pkg::BIT_RUN];
        next_overflow = bus.wdata[cawd_pkg::BIT_OVERFLOW];
        next_m4_flag  = bus.wdata[cawd_pkg::BIT_M4_MATCH];
      end else if (bus.addr == cawd_pkg::OFF_COUNTER_LOW) begin
        next_counter[7:0] = bus.wdata;
      end else if (bus.addr == cawd_pkg::OFF_COUNTER_HIGH) begin
        next_counter[15:8] = bus.wdata;
      end else if (bus.addr == cawd_pkg::OFF_M4_MODE) begin
        next_m4_mode = bus.wdata;
      end else if (bus.addr == cawd_pkg::OFF_M4_COMPARE_LOW) begin
        next_compare[7:0] = bus.wdata;
      end else if (bus.addr == cawd_pkg::OFF_M4_COMPARE_HIGH) begin
        next_compare[15:8] = bus.wdata;
      end else if (bus.addr == cawd_pkg::OFF_WD_STATUS) begin
        next_wd_fired = wd_fired & ~bus.wdata[cawd_pkg::BIT_WD_FIRED];
      end
    end
    // hardware sets win over software clears
    if (inc && counter == 16'hFFFF) begin
      next_overflow = 1'b1;
    end
    if (match) begin
      next_m4_flag = 1'b1;
    end
    if (wd_hit) begin
      next_wd_fired  = 1'b1;
      next_pulse_cnt = PULSE_W[3:0];
    end
    // read data only for the cycle after the strobe, zero otherwise
    if (bus.rd) begin
      if (bus.addr == cawd_pkg::OFF_COUNTER_MODE) begin
        next_rdata = counter_mode;
      end else if (bus.addr == cawd_pkg::OFF_COUNTER_CTRL) begin
        next_rdata = {overflow, run, 1'b0, m4_flag, 4'h0};
      end else if (bus.addr == cawd_pkg::OFF_COUNTER_LOW) begin
        next_rdata = counter[7:0];
      end else if (bus.addr == cawd_pkg::OFF_COUNTER_HIGH) begin
        next_rdata = counter[15:8];
      end else if (bus.addr == cawd_pkg::OFF_M4_MODE) begin
        next_rdata = m4_mode;
      end else if (bus.addr == cawd_pkg::OFF_M4_COMPARE_LOW) begin
        next_rdata = compare[7:0];
      end else if (bus.addr == cawd_pkg::OFF_M4_COMPARE_HIGH) begin
        next_rdata = compare[15:8];
      end else if (bus.addr == cawd_pkg::OFF_WD_STATUS) begin
        next_rdata = {7'h00, wd_fired};
      end
    end
  end

  // reset branch loads constants only
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      counter_mode <= cawd_pkg::RST_COUNTER_MODE;
      m4_mode      <= cawd_pkg::RST_M4_MODE;
      compare      <= cawd_pkg::RST_COMPARE;
      counter      <= cawd_pkg::RST_COUNTER;
      run          <= 1'b0;
      overflow     <= 1'b0;
      m4_flag      <= 1'b0;
      wd_fired     <= 1'b0;
      pulse_cnt    <= 4'h0;
      rdata        <= 8'h00;
    end else begin
      counter_mode <= next_counter_mode;
      m4_mode      <= next_m4_mode;
      compare      <= next_compare;
      counter      <= next_counter;
      run          <= next_run;
      overflow     <= next_overflow;
      m4_flag      <= next_m4_flag;
      wd_fired     <= next_wd_fired;
      pulse_cnt    <= next_pulse_cnt;
      rdata        <= next_rdata;
    end
  end

  // internal reset only; the chip's reset pin is never driven from here
  assign O_WD_RESET = (pulse_cnt != 4'h0);
  assign O_M4_MATCH = m4_flag;
  assign O_RDATA    = rdata;

  // pulse sized for the default length; a retrigger only stretches it
  sequence s_pulse_held;
    O_WD_RESET[*4];
  endsequence : s_pulse_held
  sequence s_match_seen;
    m4_flag && counter == compare;
  endsequence : s_match_seen
  sequence s_wrapped;
    counter == 16'h0000;
  endsequence : s_wrapped

  // checks sit next to the counter and flag logic they guard
  chk_wd_fires_on_match: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wd_hit |=> s_pulse_held) else $error("watchdog reset missing after match");
  chk_wd_off_silent: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (!wd_en && pulse_cnt == 4'h0) |=> !O_WD_RESET) else $error("reset with watchdog off");
  chk_overflow_set: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (inc && counter == 16'hFFFF) |=> overflow) else $error("overflow not flagged");
  chk_counter_wraps: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (inc && counter == 16'hFFFF && !count_wr) |=> s_wrapped) else $error("counter did not wrap");
  chk_overflow_sticky: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (overflow && !(bus.wr && bus.addr == cawd_pkg::OFF_COUNTER_CTRL)) |=> overflow)
    else $error("overflow flag lost");
  chk_m4_flag_set: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (match && !count_wr && !cmp_wr) |=> s_match_seen) else $error("module 4 match lost");
  chk_flag_set_wins: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    match |=> m4_flag) else $error("match flag clear won over set");
  chk_disabled_no_pulse: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (match && !wd_en) |=> !$rose(O_WD_RESET)) else $error("pulse from disabled watchdog");
  chk_only_module4: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(O_WD_RESET) |-> ($past(wd_en) && $past(m4_mode[cawd_pkg::BIT_M4_COMPARE]) && $past(inc)))
    else $error("reset without module 4 compare");
  chk_count_steps: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (inc && !count_wr) |=> counter == $past(counter) + 16'h0001) else $error("counter did not step");
  chk_compare_read: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bus.rd && bus.addr == cawd_pkg::OFF_M4_COMPARE_HIGH) |=> O_RDATA == $past(compare[15:8]))
    else $error("compare high not readable");
  chk_fired_sticky: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (wd_fired && !(bus.wr && bus.addr == cawd_pkg::OFF_WD_STATUS)) |=> wd_fired)
    else $error("fired status lost");
  chk_pulse_ends: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $fell(O_WD_RESET) |-> $past(pulse_cnt) == 4'h1) else $error("reset pulse ended early");
  chk_compare_load: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bus.wr && bus.addr == cawd_pkg::OFF_M4_COMPARE_LOW) |=> compare[7:0] == $past(bus.wdata))
    else $error("compare low not loaded");
  chk_enable_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bus.wr && bus.addr == cawd_pkg::OFF_COUNTER_MODE) |=> wd_en == $past(bus.wdata[cawd_pkg::BIT_WD_ENABLE]))
    else $error("enable bit not written");
  chk_fired_status: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(O_WD_RESET) |-> wd_fired ##1 (wd_fired || $past(bus.wr))) else $error("fired status not set");
endmodule : cawd_top
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the counter array watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk        = 1'b0;
  logic       rst        = 1'b1;
  logic       tick_in    = 1'b0;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic [7:0] rdata;
  logic       wd_reset;
  logic       m4_match;
  int         n_mismatch = 0;
  int         compares   = 0;
  always #2.5 clk = ~clk;
  cawd_top #(.PULSE_W(cawd_pkg::WD_PULSE_CYCLES)) cawd_top_i (.I_CLK(clk), .I_SYS_RST(rst),
    .I_COUNT_TICK(tick_in), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_WD_RESET(wd_reset), .O_M4_MATCH(m4_match));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic do_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_reg
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) tick_in <= 1'b1;
      @(posedge clk) tick_in <= 1'b0;
    end
  endtask : ticks
  // counter 1233, compare 1235: match lands on the second tick
  task automatic arm(input logic en);
    wr_reg(cawd_pkg::OFF_COUNTER_LOW, 8'h33);
    wr_reg(cawd_pkg::OFF_COUNTER_HIGH, 8'h12);
    wr_reg(cawd_pkg::OFF_M4_COMPARE_LOW, 8'h35);
    wr_reg(cawd_pkg::OFF_M4_COMPARE_HIGH, 8'h12);
    wr_reg(cawd_pkg::OFF_M4_MODE, 8'(1 << cawd_pkg::BIT_M4_COMPARE));
    wr_reg(cawd_pkg::OFF_COUNTER_MODE, 8'(en) << cawd_pkg::BIT_WD_ENABLE);
    wr_reg(cawd_pkg::OFF_COUNTER_CTRL, 8'(1 << cawd_pkg::BIT_RUN));
  endtask : arm
  // bounded window; counts reset cycles right after the matching tick
  task automatic pulse_len(input int exp);
    int n;
    n = 0;
    repeat (12) begin
      #1 if (wd_reset === 1'b1) n++;
      @(posedge clk);
    end
    check(8'(n), 8'(exp));
  endtask : pulse_len
  task automatic t_reset_vals();
    do_reset();
    for (int a = 0; a < 16; a++) rd_reg(4'(a), 8'h00);
    check({7'h00, wd_reset}, 8'h00);
    $display("test reset values done");
  endtask : t_reset_vals
  task automatic t_fire();
    do_reset();
    arm(1'b1);
    ticks(1);
    #1 check({7'h00, wd_reset}, 8'h00);
    ticks(1);
    #1 check({7'h00, m4_match}, 8'h01);
    pulse_len(int'(cawd_pkg::WD_PULSE_CYCLES));
    $display("test watchdog fire done");
  endtask : t_fire
  task automatic t_suppress();
    do_reset();
    arm(1'b1);
    ticks(1);
    wr_reg(cawd_pkg::OFF_COUNTER_MODE, 8'h00);
    ticks(1);
    #1 check({7'h00, m4_match}, 8'h01);
    pulse_len(0);
    wr_reg(cawd_pkg::OFF_COUNTER_LOW, 8'h33);
    wr_reg(cawd_pkg::OFF_COUNTER_MODE, 8'(1 << cawd_pkg::BIT_WD_ENABLE));
    ticks(2);
    pulse_len(int'(cawd_pkg::WD_PULSE_CYCLES));
    $display("test suppress and re-arm done");
  endtask : t_suppress
  task automatic t_overflow();
    do_reset();
    wr_reg(cawd_pkg::OFF_COUNTER_LOW, 8'hFF);
    wr_reg(cawd_pkg::OFF_COUNTER_HIGH, 8'hFF);
    wr_reg(cawd_pkg::OFF_COUNTER_CTRL, 8'(1 << cawd_pkg::BIT_RUN));
    ticks(1);
    rd_reg(cawd_pkg::OFF_COUNTER_CTRL, 8'hC0);
    rd_reg(cawd_pkg::OFF_COUNTER_LOW, 8'h00);
    rd_reg(cawd_pkg::OFF_COUNTER_HIGH, 8'h00);
    check({7'h00, wd_reset}, 8'h00);
    $display("test overflow done");
  endtask : t_overflow
  // fed by moving the compare value, then the counter, then set one step short of the compare value and ticked to fire
  task automatic t_service();
    do_reset();
    arm(1'b1);
    ticks(1);
    wr_reg(cawd_pkg::OFF_M4_COMPARE_HIGH, 8'h22);
    ticks(2);
    rd_reg(cawd_pkg::OFF_WD_STATUS, 8'h00);
    rd_reg(cawd_pkg::OFF_COUNTER_CTRL, 8'h40);
    wr_reg(cawd_pkg::OFF_COUNTER_HIGH, 8'h22);
    wr_reg(cawd_pkg::OFF_COUNTER_LOW, 8'h33);
    ticks(1);
    wr_reg(cawd_pkg::OFF_COUNTER_LOW, 8'h00);
    ticks(2);
    rd_reg(cawd_pkg::OFF_COUNTER_LOW, 8'h02);
    rd_reg(cawd_pkg::OFF_COUNTER_CTRL, 8'h40);
    wr_reg(cawd_pkg::OFF_COUNTER_LOW, 8'h34);
    ticks(1);
    pulse_len(int'(cawd_pkg::WD_PULSE_CYCLES));
    rd_reg(cawd_pkg::OFF_WD_STATUS, 8'h01);
    wr_reg(cawd_pkg::OFF_WD_STATUS, 8'h01);
    rd_reg(cawd_pkg::OFF_WD_STATUS, 8'h00);
    $display("test servicing done");
  endtask : t_service
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    t_reset_vals();
    t_fire();
    t_suppress();
    t_overflow();
    t_service();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
